// ==== src/pmw_pkg.sv ====
// -----------------------------------------------------------------------
// Shared constants of the power mode and wake-up controller
// -----------------------------------------------------------------------
package pmw_pkg;

    // -------------------------------------------------------------------
    // Clocking
    // -------------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000; // Rate of i_mclk
    localparam int SLOW_XTAL_HZ = 32768; // Slow crystal rate
    // Longest whole period of the slow clock, so round down
    localparam int SLOW_DIV = CLK_HZ / SLOW_XTAL_HZ;

    // -------------------------------------------------------------------
    // Wake-up timing
    // -------------------------------------------------------------------
    localparam int RESET_DELAY_MS = 50; // Typical external reset delay
    localparam int RESET_DELAY_CYCLES = (RESET_DELAY_MS * (CLK_HZ / 1000));
    localparam int SST_SHORT = 2; // Short start-up, system clock periods
    localparam int SST_LONG = 128; // Long start-up, system clock periods
    localparam int CNT_W = 21; // Wide enough for the reset delay

    // -------------------------------------------------------------------
    // Port and interrupt widths
    // -------------------------------------------------------------------
    localparam int PORT_W = 8; // Port A bits 0 to 7
    localparam int IRQ_N = 4; // Interrupt sources watched for wake

    // -------------------------------------------------------------------
    // Reset values of the control bits
    // -------------------------------------------------------------------
    localparam logic RST_CLK_SELECT = 1'h0; // Normal mode after reset
    localparam logic RST_LOWPOWER = 1'h0; // Quick start after power-on

    // -------------------------------------------------------------------
    // Oscillator configuration codes
    // -------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PMW_OSC_FAST_XTAL,
        PMW_OSC_EXT_RC,
        PMW_OSC_INT_RC,
        PMW_OSC_INT_RC_SLOW_XTAL
    } pmw_osc_t;

    // Wake sources, in the order that they are remembered
    typedef enum logic [1:0]
    {
        PMW_SRC_EXT,
        PMW_SRC_PORT,
        PMW_SRC_IRQ,
        PMW_SRC_WDT
    } pmw_src_t;

endpackage

// ==== src/pmw_wake_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------------
// Synchronised pin events handed from the sense block to the controller
// -----------------------------------------------------------------------
interface pmw_wake_if;
    import pmw_pkg::*;

    logic slow_tick; // One cycle per slow crystal period
    logic [PORT_W-1:0] port_fall; // Falling edge seen on a port A bit
    logic ext_rst_low; // External reset pin held low, synchronised

    // Sense side drives the events
    modport sense
    (
        output slow_tick,
        output port_fall,
        output ext_rst_low
    );

    // Controller side consumes them
    modport ctrl
    (
        input slow_tick,
        input port_fall,
        input ext_rst_low
    );
endinterface
`default_nettype wire

// ==== src/pmw_wake_sense.sv ====
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------------
// Pin synchronisers, falling edge detect and slow clock divider
// -----------------------------------------------------------------------
module pmw_wake_sense
    import pmw_pkg::*;
#(
    parameter int DIV = SLOW_DIV
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Pins
    input wire logic [PORT_W-1:0] i_port_a,
    input wire logic i_ext_reset_pin_n,
    // Events towards the controller
    pmw_wake_if.sense wake
);

    logic [PORT_W-1:0] port_meta; // First stage, read only by port_sync
    logic [PORT_W-1:0] port_sync; // Second stage
    logic [PORT_W-1:0] port_prev; // Delayed copy for edge detect
    logic rst_meta; // First stage, read only by rst_sync
    logic rst_sync; // Second stage
    logic [15:0] div_cnt; // Slow tick divider
    logic div_wrap; // Divider at its last count

    // -------------------------------------------------------------------
    // Synchronisers
    // -------------------------------------------------------------------
    // Pins idle high after reset so no false edge appears at release
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            port_meta <= '1;
            port_sync <= '1;
            port_prev <= '1;
            rst_meta <= 1'h1;
            rst_sync <= 1'h1;
        end
        else
        begin
            port_meta <= i_port_a;
            port_sync <= port_meta;
            port_prev <= port_sync;
            rst_meta <= i_ext_reset_pin_n;
            rst_sync <= rst_meta;
        end
    end

    // -------------------------------------------------------------------
    // Slow clock divider
    // -------------------------------------------------------------------
    // The slow crystal is modelled as an enable pulse on the one clock
    assign div_wrap = (div_cnt == 16'(DIV - 1));

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            div_cnt <= 16'h0;
        end
        else if (div_wrap)
        begin
            div_cnt <= 16'h0;
        end
        else
        begin
            div_cnt <= div_cnt + 16'h1;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign wake.slow_tick = div_wrap;
    assign wake.port_fall = port_prev & ~port_sync;
    assign wake.ext_rst_low = ~rst_sync;

endmodule
`default_nettype wire

// ==== src/pmw_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl
    import pmw_pkg::*;
#(
    parameter int RSTD_CYCLES = RESET_DELAY_CYCLES,
    parameter int DIV = SLOW_DIV
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Configuration option and control bits
    input wire logic [1:0] i_osc_cfg,
    input wire logic i_wdt_on_sys_clk,
    input wire logic i_ctrl_wr,
    input wire logic i_ctrl_clk_select,
    input wire logic i_ctrl_lowpower,
    // Core strobes and watchdog
    input wire logic i_halt,
    input wire logic i_clr_wdt,
    input wire logic i_wdt_overflow,
    // Pins
    input wire logic i_ext_reset_pin_n,
    input wire logic [PORT_W-1:0] i_port_a,
    input wire logic [PORT_W-1:0] i_port_wake_mask,
    // Interrupt state of the core
    input wire logic [IRQ_N-1:0] i_irq_req,
    input wire logic [IRQ_N-1:0] i_irq_enable,
    input wire logic i_stack_full,
    // Control bits read back
    output logic o_sys_clk_select,
    output logic o_slow_xtal_lowpower,
    // Oscillators and clocks
    output logic o_fast_osc_run,
    output logic o_slow_osc_run,
    output logic o_sys_tick,
    // Mode status
    output logic o_slow_mode,
    output logic o_idle,
    output logic o_sleep,
    output logic o_cpu_run,
    output logic o_io_hold,
    // Watchdog control
    output logic o_wdt_clear,
    output logic o_wdt_run,
    // Status flags
    output logic o_powerdown_flag,
    output logic o_timeout_flag,
    // Reset and resume actions
    output logic o_full_reset,
    output logic o_wdt_reset,
    output logic o_pc_sp_reset,
    output logic o_resume_next,
    output logic o_irq_service
);

    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {PMW_RUN, PMW_HALTED, PMW_RST_DELAY, PMW_STARTUP}
        pmw_state_t;

    pmw_wake_if wake(); // Synchronised pin events

    pmw_state_t state; // Operating state
    pmw_state_t next_state;
    pmw_src_t src; // Source of the last wake
    pmw_src_t next_src;
    logic [CNT_W-1:0] cnt; // Reset delay and start-up counter
    logic [CNT_W-1:0] next_cnt;
    logic sst_long; // Long start-up chosen at wake
    logic next_sst_long;
    logic clk_sel; // System clock select bit
    logic lowpower; // Slow crystal low-power bit
    logic powerdown_flag; // Power-down flag
    logic tof; // Time-out flag
    logic [IRQ_N-1:0] irq_armed; // Sources clear at halt entry
    logic [IRQ_N-1:0] irq_woke; // Sources that caused the wake
    logic port_pend; // Port wake seen while halted
    logic wdt_pend; // Watchdog overflow seen while halted
    logic full_rst; // Full reset in progress
    logic wdt_rst; // Watchdog reset pulse
    logic pc_sp_rst; // PC and SP reset pulse
    logic resume_nx; // Resume after halt pulse
    logic irq_svc; // Interrupt response pulse

    // Decoded conditions
    wire logic slow_cfg; // Internal RC plus slow crystal option
    wire logic crystal_cfg; // Crystal drives the clock after wake
    wire logic slow_mode; // System clock from slow crystal
    wire logic sys_tick; // One system clock period
    wire logic halt_take; // Halt accepted this cycle
    wire logic irq_wake; // Armed interrupt request present
    wire logic wake_any; // Some wake source pending
    wire logic sst_done; // Last start-up period
    wire logic [CNT_W-1:0] sst_end; // Start-up length minus one
    wire logic rstd_done; // Last reset delay cycle
    wire logic wdt_run_ov; // Time-out while running

    // -------------------------------------------------------------------
    // Pin sense
    // -------------------------------------------------------------------
    pmw_wake_sense #(.DIV(DIV)) u_sense (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_port_a(i_port_a),
        .i_ext_reset_pin_n(i_ext_reset_pin_n),
        .wake(wake)
    );

    // -------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------
    assign slow_cfg = (i_osc_cfg == PMW_OSC_INT_RC_SLOW_XTAL);
    assign crystal_cfg = (i_osc_cfg == PMW_OSC_FAST_XTAL) | slow_mode;
    // The select bit only counts in the slow crystal option
    assign slow_mode = clk_sel & slow_cfg;
    assign sys_tick = slow_mode ? wake.slow_tick : 1'h1;
    // Same acceptance whatever the mode
    assign halt_take = (state == PMW_RUN) & i_halt & ~wake.ext_rst_low;
    assign irq_wake = |(i_irq_req & irq_armed);
    assign wake_any = wdt_pend | irq_wake | port_pend;
    assign sst_end = sst_long ? CNT_W'(SST_LONG - 1) :
        CNT_W'(SST_SHORT - 1);
    assign sst_done = sys_tick & (cnt == sst_end);
    assign rstd_done = (cnt == CNT_W'(RSTD_CYCLES - 1));
    assign wdt_run_ov = (state == PMW_RUN) & i_wdt_overflow;

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_src = src;
        next_cnt = cnt;
        next_sst_long = sst_long;
        if (wake.ext_rst_low)
        begin
            // Pin low restarts the reset delay from any state
            next_state = PMW_RST_DELAY;
            next_src = PMW_SRC_EXT;
            next_cnt = '0;
        end
        else
            case (state)
                PMW_RUN:
                    if (halt_take)
                        next_state = PMW_HALTED;
                PMW_HALTED:
                    // Wake is taken on the slow clock, which survives
                    if (wake.slow_tick & wake_any)
                    begin
                        next_state = PMW_STARTUP;
                        next_cnt = '0;
                        next_sst_long = crystal_cfg;
                        if (wdt_pend)
                            next_src = PMW_SRC_WDT;
                        else if (irq_wake)
                            next_src = PMW_SRC_IRQ;
                        else
                            next_src = PMW_SRC_PORT;
                    end
                PMW_RST_DELAY:
                    if (rstd_done)
                    begin
                        next_state = PMW_STARTUP;
                        next_cnt = '0;
                        next_sst_long = 1'h1;
                    end
                    else
                        next_cnt = cnt + CNT_W'(1);
                PMW_STARTUP:
                    if (sst_done)
                        next_state = PMW_RUN;
                    else if (sys_tick)
                        next_cnt = cnt + CNT_W'(1);
                default:
                    next_state = PMW_RUN;
            endcase
    end

    // -------------------------------------------------------------------
    // Status flags and wake pending latches
    // -------------------------------------------------------------------
    // Flags survive both reset wakes so software can tell them apart;
    // events can arrive between slow ticks, so they are held until taken
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            powerdown_flag <= 1'h0;
            tof <= 1'h0;
            port_pend <= 1'h0;
            wdt_pend <= 1'h0;
            irq_armed <= '0;
            irq_woke <= '0;
        end
        else
        begin
            if (halt_take)
                powerdown_flag <= 1'h1;
            else if (i_clr_wdt)
                powerdown_flag <= 1'h0;
            // A time-out in the halt cycle still sets the flag
            if (i_wdt_overflow & (state != PMW_RST_DELAY))
                tof <= 1'h1;
            else if (halt_take)
                tof <= 1'h0;
            if (halt_take)
                irq_armed <= ~i_irq_req;
            if (state == PMW_HALTED)
            begin
                port_pend <= port_pend |
                    |(wake.port_fall & i_port_wake_mask);
                wdt_pend <= wdt_pend | i_wdt_overflow;
                if (next_state == PMW_STARTUP)
                    irq_woke <= i_irq_req & irq_armed;
            end
            else
            begin
                port_pend <= 1'h0;
                wdt_pend <= 1'h0;
            end
        end
    end

    // -------------------------------------------------------------------
    // State, control bits and reset actions
    // -------------------------------------------------------------------
    // Writes only land while running; a halted core issues none
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state <= PMW_RUN;
            src <= PMW_SRC_EXT;
            cnt <= '0;
            sst_long <= 1'h0;
            clk_sel <= RST_CLK_SELECT;
            lowpower <= RST_LOWPOWER;
            full_rst <= 1'h0;
            wdt_rst <= 1'h0;
            pc_sp_rst <= 1'h0;
            resume_nx <= 1'h0;
            irq_svc <= 1'h0;
        end
        else
        begin
            state <= next_state;
            src <= next_src;
            cnt <= next_cnt;
            sst_long <= next_sst_long;
            if (state == PMW_RST_DELAY)
                clk_sel <= RST_CLK_SELECT;
            else if (i_ctrl_wr & (state == PMW_RUN))
            begin
                clk_sel <= i_ctrl_clk_select;
                lowpower <= i_ctrl_lowpower;
            end
            full_rst <= (next_state == PMW_RST_DELAY) |
                ((next_state == PMW_STARTUP) & (next_src == PMW_SRC_EXT));
            wdt_rst <= wdt_run_ov;
            pc_sp_rst <= sst_done & (state == PMW_STARTUP) &
                (src == PMW_SRC_WDT) & ~wake.ext_rst_low;
            // The core leaves the request pending when not serviced
            resume_nx <= sst_done & (state == PMW_STARTUP) &
                ~wake.ext_rst_low & ((src == PMW_SRC_PORT) |
                ((src == PMW_SRC_IRQ) &
                ~(|(irq_woke & i_irq_enable) & ~i_stack_full)));
            irq_svc <= sst_done & (state == PMW_STARTUP) &
                ~wake.ext_rst_low & (src == PMW_SRC_IRQ) &
                |(irq_woke & i_irq_enable) & ~i_stack_full;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign o_sys_clk_select = clk_sel;
    assign o_slow_xtal_lowpower = lowpower;
    // Fast RC idles in Slow mode and whenever halted
    assign o_fast_osc_run = (state != PMW_HALTED) & ~slow_mode;
    assign o_slow_osc_run = slow_cfg;
    assign o_sys_tick = sys_tick & (state == PMW_RUN);
    assign o_slow_mode = slow_mode;
    assign o_idle = (state == PMW_HALTED) & slow_cfg;
    assign o_sleep = (state == PMW_HALTED) & ~slow_cfg;
    assign o_cpu_run = (state == PMW_RUN);
    assign o_io_hold = (state == PMW_HALTED) | (state == PMW_STARTUP);
    assign o_wdt_clear = halt_take | i_clr_wdt;
    assign o_wdt_run = (state != PMW_HALTED) | ~i_wdt_on_sys_clk;
    assign o_powerdown_flag = powerdown_flag;
    assign o_timeout_flag = tof;
    assign o_full_reset = full_rst;
    assign o_wdt_reset = wdt_rst;
    assign o_pc_sp_reset = pc_sp_rst;
    assign o_resume_next = resume_nx;
    assign o_irq_service = irq_svc;

endmodule
`default_nettype wire

// ==== testbench/pmw_ctrl_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// --------
// Checker on the mode controller's ports
// --------
module pmw_ctrl_asserts
(
    // Clock, reset and inputs
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [1:0] i_osc_cfg,
    input wire logic i_wdt_on_sys_clk,
    input wire logic i_halt,
    input wire logic i_clr_wdt,
    input wire logic i_wdt_overflow,
    input wire logic i_ext_reset_pin_n,
    // Outputs watched
    input wire logic o_fast_osc_run,
    input wire logic o_sys_tick,
    input wire logic o_idle,
    input wire logic o_sleep,
    input wire logic o_cpu_run,
    input wire logic o_io_hold,
    input wire logic o_wdt_clear,
    input wire logic o_wdt_run,
    input wire logic o_powerdown_flag,
    input wire logic o_timeout_flag,
    input wire logic o_wdt_reset
);
    logic [2:0] pin_hist; // Pin samples, spans the sync lag
    logic pin_ok; // Reset pin quiet long enough
    logic halted; // Idle or Sleep
    logic take; // Halt that the block must accept
    assign pin_ok = (&pin_hist) && i_ext_reset_pin_n;
    assign halted = o_idle || o_sleep;
    assign take = i_halt && o_cpu_run && pin_ok;

    // Keeps reset-pin traffic out of the other relations
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            pin_hist <= 3'h7;
        else
            pin_hist <= {pin_hist[1:0], i_ext_reset_pin_n};
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    property p_idle_sel;
        halted |-> (o_idle == (i_osc_cfg == 2'h3)) && !(o_idle && o_sleep);
    endproperty
    a_idle_sel: assert property (p_idle_sel)
        else $error("halt mode wrong");
    property p_clk_stop;
        halted |-> !o_fast_osc_run && !o_sys_tick && o_io_hold && !o_cpu_run;
    endproperty
    a_clk_stop: assert property (p_clk_stop)
        else $error("clock or core not frozen");
    property p_halt_flags;
        take && !i_wdt_overflow |=> halted && o_powerdown_flag
            && !o_timeout_flag;
    endproperty
    a_halt_flags: assert property (p_halt_flags)
        else $error("halt flags wrong");
    property p_halt_clr;
        take |-> o_wdt_clear;
    endproperty
    a_halt_clr: assert property (p_halt_clr)
        else $error("halt did not clear watchdog");
    property p_wdt_stop;
        halted |-> (o_wdt_run != i_wdt_on_sys_clk);
    endproperty
    a_wdt_stop: assert property (p_wdt_stop)
        else $error("watchdog run wrong in halt");
    property p_clr_pdn;
        i_clr_wdt && !i_halt && o_cpu_run && pin_ok |=> !o_powerdown_flag;
    endproperty
    a_clr_pdn: assert property (p_clr_pdn)
        else $error("power-down flag not cleared");
    property p_run_wdt;
        o_cpu_run && i_wdt_overflow && !i_halt && pin_ok
            |=> o_wdt_reset && o_timeout_flag;
    endproperty
    a_run_wdt: assert property (p_run_wdt)
        else $error("running time-out not handled");
    property p_short_sst;
        $fell(halted) && i_osc_cfg == 2'h2 && pin_ok
            |-> !o_cpu_run ##1 !o_cpu_run ##1 o_cpu_run;
    endproperty
    a_short_sst: assert property (p_short_sst)
        else $error("short start-up length wrong");

    c_idle: cover property (o_idle);
    c_wdt: cover property (o_wdt_reset);
    c_wake: cover property ($fell(halted) ##3 o_cpu_run);
endmodule
bind pmw_ctrl pmw_ctrl_asserts u_chk (.i_mclk, .i_nrst, .i_osc_cfg,
    .i_wdt_on_sys_clk, .i_halt, .i_clr_wdt, .i_wdt_overflow,
    .i_ext_reset_pin_n, .o_fast_osc_run, .o_sys_tick, .o_idle, .o_sleep,
    .o_cpu_run, .o_io_hold, .o_wdt_clear, .o_wdt_run, .o_powerdown_flag,
    .o_timeout_flag, .o_wdt_reset);
`default_nettype wire

// ==== testbench/pmw_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// --------
// Core model: executes halt or clear-watchdog
// --------
module pmw_core_model
(
    // Clock and core state
    input wire logic i_mclk,
    input wire logic i_cpu_run,
    // Strobes to the controller
    output logic o_halt,
    output logic o_clr_wdt
);
    initial
    begin
        o_halt = 1'b0;
        o_clr_wdt = 1'b0;
    end

    // Only a running core executes, so a stalled core waits first
    task automatic strobe(input logic h);
        while (!i_cpu_run)
            @(posedge i_mclk) #1;
        o_halt = h;
        o_clr_wdt = !h;
        @(posedge i_mclk);
        #1 o_halt = 1'b0;
        o_clr_wdt = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== testbench/pmw_ctrl_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl_test;
    localparam int DV = 4; // Shortened slow tick divider
    logic clk = 1'b0;
    logic nrst, wr, csel, lp, ovf, pin_n, wsys, stk, halt, clr;
    logic [1:0] cfg;
    logic [7:0] pa, mask;
    logic [3:0] irq, ien;
    logic sel, lpw, fosc, sosc, smode, idle, sleep, run, wrun;
    logic pdn, tmo, frst, wrst, pcsp, rnx, isv, tick, hold, wclr;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    always #20 clk = ~clk;

    pmw_ctrl #(.RSTD_CYCLES(8), .DIV(DV)) dut
    (
        .i_mclk(clk), .i_nrst(nrst), .i_osc_cfg(cfg),
        .i_wdt_on_sys_clk(wsys), .i_ctrl_wr(wr),
        .i_ctrl_clk_select(csel), .i_ctrl_lowpower(lp),
        .i_halt(halt), .i_clr_wdt(clr), .i_wdt_overflow(ovf),
        .i_ext_reset_pin_n(pin_n), .i_port_a(pa),
        .i_port_wake_mask(mask), .i_irq_req(irq),
        .i_irq_enable(ien), .i_stack_full(stk),
        .o_sys_clk_select(sel), .o_slow_xtal_lowpower(lpw),
        .o_fast_osc_run(fosc), .o_slow_osc_run(sosc),
        .o_sys_tick(tick), .o_slow_mode(smode), .o_idle(idle),
        .o_sleep(sleep), .o_cpu_run(run), .o_io_hold(hold),
        .o_wdt_clear(wclr), .o_wdt_run(wrun),
        .o_powerdown_flag(pdn), .o_timeout_flag(tmo),
        .o_full_reset(frst), .o_wdt_reset(wrst),
        .o_pc_sp_reset(pcsp), .o_resume_next(rnx), .o_irq_service(isv)
    );
    pmw_core_model core (.i_mclk(clk), .i_cpu_run(run), .o_halt(halt),
        .o_clr_wdt(clr));

    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Waits out the halt, then counts start-up cycles; bounded
    task automatic wake(output int k);
        k = 0;
        while ((idle || sleep) && k < 5000)
        begin
            k++;
            step(1);
        end
        k = 0;
        while (!run && k < 5000)
        begin
            k++;
            step(1);
        end
    endtask
    task automatic ctl(input logic s, input logic l);
        wr = 1'b1;
        csel = s;
        lp = l;
        step(1);
        wr = 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Slow mode, idle, masked and unmasked port edges
    task automatic t_slow;
        chk("lpw", 0, lpw);
        chk("pdn", 0, pdn);
        cfg = 2'h3;
        ctl(1'b1, 1'b1);
        chk("smode", 1, smode);
        chk("sel", 1, sel);
        chk("lpw", 1, lpw);
        chk("fosc", 0, fosc);
        chk("sosc", 1, sosc);
        core.strobe(1'b1);
        chk("idle", 1, idle);
        chk("pdn", 1, pdn);
        chk("tick", 0, tick);
        chk("hold", 1, hold);
        chk("wclr", 0, wclr);
        mask = 8'h01;
        pa[1] = 1'b0;
        step(4 * DV + 4);
        chk("masked", 1, idle);
        pa[0] = 1'b0;
        wake(n);
        chk("rnx", 1, rnx);
        pa = 8'hff;
        ctl(1'b0, 1'b0);
        chk("smode", 0, smode);
        $display("t_slow done");
    endtask
    // Running overflow, then clear-watchdog
    task automatic t_wdt_run;
        ovf = 1'b1;
        step(1);
        ovf = 1'b0;
        chk("wrst", 1, wrst);
        chk("tmo", 1, tmo);
        core.strobe(1'b0);
        chk("pdn", 0, pdn);
        $display("t_wdt_run done");
    endtask
    // Pending flag blocks wake; a new enabled request is serviced
    task automatic t_irq;
        cfg = 2'h2;
        irq = 4'h2;
        ien = 4'h4;
        core.strobe(1'b1);
        chk("sleep", 1, sleep);
        chk("tmo", 0, tmo);
        step(3 * DV);
        chk("pending", 1, sleep);
        irq = 4'h6;
        wake(n);
        chk("sst", 2, n);
        chk("isv", 1, isv);
        for (int i = 0; i < 2; i++)
        begin
            irq = 4'h0;
            ien = i ? 4'h0 : 4'h8;
            stk = !i;
            core.strobe(1'b1);
            irq = 4'h8;
            wake(n);
            chk("rnx", 1, rnx);
            chk("isv", 0, isv);
        end
        irq = 4'h0;
        stk = 1'b0;
        $display("t_irq done");
    endtask
    // Watchdog wake from sleep on fast crystal, long start-up
    task automatic t_wdt_halt;
        cfg = 2'h0;
        wsys = 1'b1;
        core.strobe(1'b1);
        chk("wrun", 0, wrun);
        ovf = 1'b1;
        step(1);
        ovf = 1'b0;
        chk("tmo", 1, tmo);
        wake(n);
        chk("sst", 128, n);
        chk("pcsp", 1, pcsp);
        chk("pdn", 1, pdn);
        wsys = 1'b0;
        $display("t_wdt_halt done");
    endtask
    // Reset pin wakes with full reset and the reset delay
    task automatic t_ext;
        cfg = 2'h2;
        core.strobe(1'b1);
        pin_n = 1'b0;
        step(6);
        chk("frst", 1, frst);
        pin_n = 1'b1;
        wake(n);
        chk("delay", 1, n > 136);
        chk("pdn", 1, pdn);
        $display("t_ext done");
    endtask

    initial
    begin
        {nrst, wr, csel, lp, ovf, wsys, stk} = 7'h00;
        pin_n = 1'b1;
        cfg = 2'h2;
        pa = 8'hff;
        mask = 8'h00;
        irq = 4'h0;
        ien = 4'h0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        t_slow;
        t_wdt_run;
        t_irq;
        t_wdt_halt;
        t_ext;
        stop_test;
    end
    // Cuts a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            stop_test;
        end
    end
endmodule
`default_nettype wire
